// File: hw/usb_port_seq.sv
// USB host port sequencer for bus reset, operational start and suspend, with an APB register file.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module usb_port_seq #(
  parameter int unsigned SPEED_CYC    = usb_port_seq_pkg::SPEED_CYC,
  parameter int unsigned TERM_CYC     = usb_port_seq_pkg::TERM_CYC,
  parameter int unsigned DONE_CYC     = usb_port_seq_pkg::DONE_CYC,
  parameter int unsigned FIRST_FS_CYC = usb_port_seq_pkg::FIRST_FS_CYC,
  parameter int unsigned FIRST_HS_CYC = usb_port_seq_pkg::FIRST_HS_CYC,
  parameter int unsigned SUSP_CYC     = usb_port_seq_pkg::SUSP_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        dev_chirp_in,
  input  wire logic        bus_idle,
  output logic [1:0]       xcvr_select,
  output logic             term_select,
  output logic [1:0]       op_mode,
  output logic             drive_se0,
  output logic             chirp_det_en,
  output logic             disc_det_en,
  output logic             sof_pulse,
  output logic             keepalive_pulse,
  output logic             irq
);
  import usb_port_seq_pkg::*;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    S_IDLE      = 4'h0,
    S_RST_SPEED = 4'h1,
    S_RST_TERM  = 4'h2,
    S_RST_DONE  = 4'h3,
    S_RST_END   = 4'h4,
    S_RUN_FIRST = 4'h5,
    S_RUN       = 4'h6,
    S_SUSP_IDLE = 4'h7,
    S_SUSP_WAIT = 4'h8,
    S_SUSPENDED = 4'h9
  } seq_state_t;

  seq_state_t    state_r,   state_nxt;
  phase_t        phase_r,   phase_nxt;
  logic [31:0]   cnt_r,     cnt_nxt;
  logic [1:0]    rate_r;
  logic [2:0]    mask_r;
  logic [2:0]    event_r,   event_nxt;
  logic [1:0]    speed_r,   speed_nxt;
  logic [1:0]    xcvr_r,    xcvr_nxt;
  logic          term_r,    term_nxt;
  logic [1:0]    opm_r,     opm_nxt;
  logic          se0_r,     se0_nxt;
  logic          chirp_r,   chirp_nxt;
  logic          disc_r,    disc_nxt;
  logic          sof_r,     sof_nxt;
  logic          ka_r,      ka_nxt;
  logic          irq_r;
  logic          pready_r;
  logic [31:0]   prdata_r;
  logic          pslverr_r;
  logic          sync1_r,   sync2_r,  sync3_r;
  logic          chirp_lvl_r;
  logic [EV_W-1:0] ev_set;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // One wait state: the answer comes from flops, so pready rises on the second access cycle.
  wire           access    = psel & penable;
  wire           fire      = access & pready_r;
  wire           wr_fire   = fire & pwrite;
  wire           hit_ctrl  = (paddr == ADDR_CTRL);
  wire           hit_stat  = (paddr == ADDR_STATUS);
  wire           hit_event = (paddr == ADDR_EVENT);
  wire           hit_mask  = (paddr == ADDR_MASK);
  wire           mapped    = hit_ctrl | hit_stat | hit_event | hit_mask;
  wire           ctrl_wr   = wr_fire & hit_ctrl;
  wire [2:0]     cmd_field = pwdata[CTRL_CMD_LSB +: 3];
  wire           cmd_reset = ctrl_wr & (cmd_field == CMD_BUS_RESET);
  wire           cmd_run   = ctrl_wr & (cmd_field == CMD_RUN);
  wire           cmd_sleep = ctrl_wr & (cmd_field == CMD_SLEEP);
  wire [EV_W-1:0] ev_clr   = (wr_fire & hit_event) ? pwdata[EV_W-1:0] : '0;
  // A new reset takes the link rate being written in the same cycle.
  wire [1:0]     rate_eff  = ctrl_wr ? pwdata[CTRL_RATE_LSB +: 2] : rate_r;

  // Status word gathers the live port state for software.
  wire [31:0]    status_word = {9'h000, se0_r, disc_r, chirp_r, 2'h0, opm_r, 3'h0, term_r,
                                2'h0, xcvr_r, 2'h0, speed_r, 1'b0, phase_r};
  wire [31:0]    rd_mux = hit_ctrl  ? {26'h0, rate_r, 4'h0} :
                          hit_stat  ? status_word :
                          hit_event ? {29'h0, event_r} :
                          hit_mask  ? {29'h0, mask_r} : 32'h0;

  // ****************************************************************
  // Timer compares
  // ****************************************************************
  wire           at_speed  = (cnt_r >= SPEED_CYC);
  wire           at_term   = (cnt_r >= TERM_CYC);
  wire           at_done   = (cnt_r >= DONE_CYC);
  wire           at_susp   = (cnt_r >= SUSP_CYC);
  wire           is_hs     = (speed_r == SPD_HS);
  wire [31:0]    frame_cyc = is_hs ? FIRST_HS_CYC : FIRST_FS_CYC;
  wire           at_frame  = (cnt_r >= frame_cyc - 32'h1);
  wire [31:0]    cnt_inc   = cnt_r + 32'h1;

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    cnt_nxt   = cnt_inc;
    speed_nxt = speed_r;
    xcvr_nxt  = xcvr_r;
    term_nxt  = term_r;
    opm_nxt   = opm_r;
    se0_nxt   = se0_r;
    chirp_nxt = chirp_r;
    disc_nxt  = disc_r;
    sof_nxt   = 1'b0;
    ka_nxt    = 1'b0;
    ev_set    = '0;
    if (cmd_reset) begin
      // Reset starts here: HS transceiver and termination, normal opmode, SE0 on the lines.
      state_nxt = S_RST_SPEED;
      phase_nxt = PH_RESET;
      xcvr_nxt  = XCVR_HS;
      term_nxt  = TERM_HS;
      opm_nxt   = OPM_NORMAL;
      se0_nxt   = 1'b1;
      chirp_nxt = (rate_eff == RATE_HSFS);
      speed_nxt = (rate_eff == RATE_LS) ? SPD_LS : SPD_HS;
      disc_nxt  = 1'b0;
      cnt_nxt   = 32'h0;
    end else if (cmd_run) begin
      // Firmware is trusted to send this only after the reset has ended.
      state_nxt = S_RUN_FIRST;
      phase_nxt = PH_OPERATIONAL;
      opm_nxt   = OPM_NORMAL;
      disc_nxt  = 1'b1;
      se0_nxt   = 1'b0;
      chirp_nxt = 1'b0;
      cnt_nxt   = 32'h0;
    end else if (cmd_sleep) begin
      // Detection is off until the port has settled in suspend.
      state_nxt = S_SUSP_IDLE;
      phase_nxt = PH_SUSPEND;
      disc_nxt  = 1'b0;
      chirp_nxt = 1'b0;
      cnt_nxt   = 32'h0;
    end else begin
      unique case (state_r)
        S_IDLE, S_RST_END, S_SUSPENDED: begin
          cnt_nxt = cnt_r;
        end
        S_RST_SPEED: begin
          if (chirp_r && chirp_lvl_r) begin
            // A device chirp hands the port to the high-speed handshake elsewhere.
            chirp_nxt = 1'b0;
            state_nxt = S_RST_TERM;
          end else if (at_speed) begin
            chirp_nxt = 1'b0;
            opm_nxt   = OPM_NO_BSNZ;
            state_nxt = S_RST_TERM;
            if (speed_r == SPD_LS) begin
              xcvr_nxt = XCVR_LS;
            end else begin
              xcvr_nxt  = XCVR_FS;
              speed_nxt = SPD_FS;
            end
          end
        end
        S_RST_TERM: begin
          if (at_term) begin
            // Counter keeps running from the command, so the 50 ms spans the whole reset.
            term_nxt  = TERM_FS;
            se0_nxt   = 1'b0;
            cnt_nxt   = 32'h0;
            state_nxt = S_RST_DONE;
          end
        end
        S_RST_DONE: begin
          if (at_done) begin
            ev_set[EV_RESET_DONE] = 1'b1;
            state_nxt = S_RST_END;
            cnt_nxt   = cnt_r;
          end
        end
        S_RUN_FIRST, S_RUN: begin
          // One frame mark per period; the first falls mid-window after the command.
          if (at_frame) begin
            cnt_nxt   = 32'h0;
            state_nxt = S_RUN;
            if (speed_r == SPD_LS) begin
              ka_nxt = 1'b1;
            end else begin
              sof_nxt = 1'b1;
            end
            if (state_r == S_RUN_FIRST) begin
              ev_set[EV_FIRST_FRAME] = 1'b1;
            end
          end
        end
        S_SUSP_IDLE: begin
          // Wait for the transaction in flight, then power the transceiver down.
          cnt_nxt = 32'h0;
          if (bus_idle) begin
            opm_nxt   = OPM_PWRDN;
            state_nxt = S_SUSP_WAIT;
            if (is_hs) begin
              xcvr_nxt = XCVR_FS;
              term_nxt = TERM_FS;
            end
          end
        end
        S_SUSP_WAIT: begin
          if (at_susp) begin
            disc_nxt  = 1'b1;
            ev_set[EV_SUSP_DONE] = 1'b1;
            state_nxt = S_SUSPENDED;
            cnt_nxt   = cnt_r;
          end
        end
        default: begin
          state_nxt = S_IDLE;
          cnt_nxt   = 32'h0;
        end
      endcase
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  assign event_nxt = (event_r & ~ev_clr) | ev_set;

  // ****************************************************************
  // Chirp input synchroniser
  // ****************************************************************
  // Three stages; the level only moves when the last two stages agree, which filters a one-cycle glitch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r     <= 1'b0;
      sync2_r     <= 1'b0;
      sync3_r     <= 1'b0;
      chirp_lvl_r <= 1'b0;
    end else begin
      sync1_r     <= dev_chirp_in;
      sync2_r     <= sync1_r;
      sync3_r     <= sync2_r;
      chirp_lvl_r <= (sync2_r == sync3_r) ? sync3_r : chirp_lvl_r;
    end
  end

  // ****************************************************************
  // Sequencer registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      phase_r <= PH_IDLE;
      cnt_r   <= 32'h0;
      speed_r <= SPD_HS;
      xcvr_r  <= XCVR_HS;
      term_r  <= TERM_HS;
      opm_r   <= OPM_NORMAL;
      se0_r   <= 1'b0;
      chirp_r <= 1'b0;
      disc_r  <= 1'b0;
      sof_r   <= 1'b0;
      ka_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      cnt_r   <= cnt_nxt;
      speed_r <= speed_nxt;
      xcvr_r  <= xcvr_nxt;
      term_r  <= term_nxt;
      opm_r   <= opm_nxt;
      se0_r   <= se0_nxt;
      chirp_r <= chirp_nxt;
      disc_r  <= disc_nxt;
      sof_r   <= sof_nxt;
      ka_r    <= ka_nxt;
    end
  end

  // ****************************************************************
  // Register file and interrupt
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_r  <= RATE_RST;
      mask_r  <= MASK_RST;
      event_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      rate_r  <= rate_eff;
      mask_r  <= (wr_fire && hit_mask) ? pwdata[EV_W-1:0] : mask_r;
      event_r <= event_nxt;
      irq_r   <= |(event_nxt & mask_r);  // Level, set and cleared in the same cycle as the flag.
    end
  end

  // APB answer flops; pready pulses for exactly one cycle per transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= access & ~pready_r;
      prdata_r  <= (access && !pready_r && !pwrite) ? rd_mux : 32'h0;
      pslverr_r <= access & ~pready_r & ~mapped;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pready          = pready_r;
  assign prdata          = prdata_r;
  assign pslverr         = pslverr_r;
  assign xcvr_select     = xcvr_r;
  assign term_select     = term_r;
  assign op_mode         = opm_r;
  assign drive_se0       = se0_r;
  assign chirp_det_en    = chirp_r;
  assign disc_det_en     = disc_r;
  assign sof_pulse       = sof_r;
  assign keepalive_pulse = ka_r;
  assign irq             = irq_r;

endmodule // usb_port_seq

// File: hw/usb_port_seq_pkg.sv
// Constants, encodings and timing counts for the USB host port reset sequencer.
// How it works
// - A bus reset command at once shows the reset phase, selects high-speed transceiver and termination, and sets normal opmode.
// - With the HS/FS link rate, device chirp detection is switched on as the reset command is taken.
// - With HS/FS and no chirp seen, more than 7.0 ms into the reset the port becomes full-speed and chirp detection goes off.
// - With the LS link rate no chirp is awaited and more than 7.0 ms into the reset the transceiver goes low-speed.
// - For FS and LS resets the termination goes full-speed only after more than 50 ms from the reset command.
// - The reset done event is raised more than 150 us after the termination switch, ending the reset.
// - After an FS reset and a running command the first SOF leaves 0.9 ms to 1.1 ms after the command, within 3 ms of the termination switch.
// - After an LS reset and a running command the first keep-alive leaves 0.9 ms to 1.1 ms after the command, within 3 ms of the termination switch.
// - A running command at once shows the operational phase and sets normal opmode.
// - A running command at once switches on disconnection detection.
// - In the operational phase SOFs are sent for HS and FS and keep-alives for LS, frame after frame.
// - The first SOF or keep-alive follows the running command by 120 us to 130 us on HS, and by 0.9 ms to 1.1 ms on FS or LS.
// - A sleep command runs the hardware steps that bring the port into suspend.
package usb_port_seq_pkg;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVENT  = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_CMD_LSB   = 0;
  localparam int CTRL_RATE_LSB  = 4;
  localparam int ST_PHASE_LSB   = 0;
  localparam int ST_SPEED_LSB   = 4;
  localparam int ST_XCVR_LSB    = 8;
  localparam int ST_TERM_BIT    = 12;
  localparam int ST_OPMODE_LSB  = 16;
  localparam int ST_CHIRP_BIT   = 20;
  localparam int ST_DISC_BIT    = 21;
  localparam int ST_SE0_BIT     = 22;
  localparam int EV_RESET_DONE  = 0;
  localparam int EV_FIRST_FRAME = 1;
  localparam int EV_SUSP_DONE   = 2;
  localparam int EV_W           = 3;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0, CMD_BUS_RESET = 3'h1, CMD_RUN = 3'h2, CMD_SLEEP = 3'h3
  } seq_cmd_t;
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0, PH_RESET = 3'h1, PH_OPERATIONAL = 3'h2, PH_SUSPEND = 3'h3
  } phase_t;
  localparam logic [1:0] RATE_HSFS   = 2'h0;
  localparam logic [1:0] RATE_LS     = 2'h2;
  localparam logic [1:0] SPD_HS      = 2'h0;
  localparam logic [1:0] SPD_FS      = 2'h1;
  localparam logic [1:0] SPD_LS      = 2'h2;
  localparam logic [1:0] XCVR_HS     = 2'h0;
  localparam logic [1:0] XCVR_FS     = 2'h1;
  localparam logic [1:0] XCVR_LS     = 2'h2;
  localparam logic       TERM_HS     = 1'b0;
  localparam logic       TERM_FS     = 1'b1;
  localparam logic [1:0] OPM_NORMAL  = 2'h0;
  localparam logic [1:0] OPM_NO_BSNZ = 2'h2;
  localparam logic [1:0] OPM_PWRDN   = 2'h3;
  localparam logic [1:0] RATE_RST    = RATE_HSFS;
  localparam logic [2:0] MASK_RST    = 3'h0;

  // ****************************************************************
  // Timing, times in ns and derived cycle counts at 250 MHz
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned T_SPEED_NS     = 7000000;
  localparam int unsigned T_TERM_NS      = 50000000;
  localparam int unsigned T_DONE_NS      = 150000;
  localparam int unsigned T_FIRST_FS_NS  = 1000000;
  localparam int unsigned T_FIRST_HS_NS  = 125000;
  localparam int unsigned T_SUSP_NS      = 5000000;
  // Least times, strictly exceeded: round up and add one cycle.
  localparam int unsigned SPEED_CYC    = (T_SPEED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned TERM_CYC     = (T_TERM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned DONE_CYC     = (T_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned SUSP_CYC     = (T_SUSP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  // Frame marks sit mid-window, so either rounding stays inside.
  localparam int unsigned FIRST_FS_CYC = T_FIRST_FS_NS / CLK_PERIOD_NS;
  localparam int unsigned FIRST_HS_CYC = T_FIRST_HS_NS / CLK_PERIOD_NS;

endpackage

// File: testbench/usb_dev_model.sv
// Behavioural downstream USB device that may answer a bus reset with a chirp.
`timescale 1ns/10ps
module usb_dev_model (
  input  wire logic pclk,
  input  wire logic hs_dev,
  input  wire logic drive_se0,
  output logic      dev_chirp_in
);
  int se0_cnt = 0;
  // A capable device chirps after some SE0 and stops well before the host gives up waiting.
  always @(posedge pclk) begin
    se0_cnt      <= drive_se0 ? se0_cnt + 1 : 0;
    dev_chirp_in <= hs_dev && se0_cnt >= 2 && se0_cnt < 16;
  end
  initial dev_chirp_in = 1'b0;
endmodule // usb_dev_model

// File: testbench/usb_port_seq_properties.sv
// Port-level checker for the USB host port sequencer.
`timescale 1ns/10ps
module usb_port_seq_checker #(
  parameter int unsigned SPEED_CYC    = 20,
  parameter int unsigned TERM_CYC     = 60,
  parameter int unsigned DONE_CYC     = 10,
  parameter int unsigned FIRST_FS_CYC = 40,
  parameter int unsigned FIRST_HS_CYC = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [1:0]  xcvr_select,
  input wire logic        term_select,
  input wire logic [1:0]  op_mode,
  input wire logic        drive_se0,
  input wire logic        chirp_det_en,
  input wire logic        disc_det_en,
  input wire logic        sof_pulse,
  input wire logic        keepalive_pulse,
  input wire logic        irq
);
  import usb_port_seq_pkg::*;
  // ****
  // Helper logic
  // ****
  // Completed writes and the command they carry.
  wire        wr_done   = psel & penable & pready & pwrite;
  wire        ctl_wr    = wr_done & (paddr == ADDR_CTRL);
  wire [2:0]  cmd       = pwdata[2:0];
  wire [31:0] first_cyc = (xcvr_select == XCVR_HS) ? FIRST_HS_CYC : FIRST_FS_CYC;
  logic        in_rst_r, first_r;
  logic [31:0] cnt_r, tcnt_r, rcnt_r;
  // Cycle counts since reset command, termination switch and run command.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {in_rst_r, first_r, cnt_r, tcnt_r, rcnt_r} <= '0;
    end else begin
      cnt_r  <= (ctl_wr && cmd == CMD_BUS_RESET) ? 32'h1 : cnt_r + 32'h1;
      tcnt_r <= $rose(term_select) ? 32'h1 : tcnt_r + 32'h1;
      rcnt_r <= (ctl_wr && cmd == CMD_RUN) ? 32'h1 : rcnt_r + 32'h1;
      if (ctl_wr && cmd != CMD_NONE && cmd < 3'h4) in_rst_r <= (cmd == CMD_BUS_RESET);
      if (ctl_wr && cmd == CMD_RUN) first_r <= 1'b1;
      else if (sof_pulse || keepalive_pulse) first_r <= 1'b0;
    end
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_reset_cmd; ctl_wr && cmd == CMD_BUS_RESET; endsequence
  sequence s_run_cmd; ctl_wr && cmd == CMD_RUN; endsequence
  sequence s_sleep_cmd; ctl_wr && cmd == CMD_SLEEP; endsequence
  sequence s_no_chirp; !chirp_det_en ##1 !chirp_det_en; endsequence
  AST_RESET_ENTRY: assert property (s_reset_cmd |-> ##[1:2] (xcvr_select == XCVR_HS &&
    term_select == TERM_HS && op_mode == OPM_NORMAL && drive_se0)) else $error("reset entry outputs wrong");
  AST_CHIRP_ON: assert property ((ctl_wr && cmd == CMD_BUS_RESET && pwdata[5:4] == RATE_HSFS)
    |-> ##[1:2] chirp_det_en) else $error("chirp detection not enabled");
  AST_LS_NO_CHIRP: assert property ((ctl_wr && cmd == CMD_BUS_RESET && pwdata[5:4] == RATE_LS)
    |-> ##1 s_no_chirp) else $error("chirp detection on for low speed");
  AST_SPEED_SWITCH: assert property (($changed(xcvr_select) && in_rst_r && xcvr_select != XCVR_HS)
    |-> (cnt_r >= SPEED_CYC && cnt_r <= SPEED_CYC + 4 && op_mode == OPM_NO_BSNZ && !chirp_det_en))
    else $error("speed switch timing or companions wrong");
  AST_TERM_SWITCH: assert property (($rose(term_select) && in_rst_r) |-> (cnt_r >= TERM_CYC &&
    cnt_r <= TERM_CYC + 4 && !drive_se0 && $past(drive_se0))) else $error("termination switch wrong");
  AST_RESET_DONE: assert property (($rose(irq) && in_rst_r && !$past(wr_done) && !$past(wr_done, 2))
    |-> (tcnt_r >= DONE_CYC && tcnt_r <= DONE_CYC + 3)) else $error("reset done at wrong time");
  AST_RUN_ENTRY: assert property (s_run_cmd |-> ##[1:2] (op_mode == OPM_NORMAL && disc_det_en))
    else $error("run entry outputs wrong");
  AST_FIRST_FRAME: assert property ((first_r && (sof_pulse || keepalive_pulse))
    |-> (rcnt_r * 10 >= first_cyc * 9 && rcnt_r * 10 <= first_cyc * 11 + 10)) else $error("first frame late or early");
  AST_FRAME_KIND: assert property ((sof_pulse || keepalive_pulse)
    |-> (keepalive_pulse == (xcvr_select == XCVR_LS))) else $error("frame kind does not match speed");
  AST_SLEEP_ENTRY: assert property (s_sleep_cmd |-> ##[1:2] !disc_det_en)
    else $error("disconnect detection still on in sleep");
endmodule // usb_port_seq_checker
bind usb_port_seq usb_port_seq_checker #(.SPEED_CYC(SPEED_CYC), .TERM_CYC(TERM_CYC), .DONE_CYC(DONE_CYC),
  .FIRST_FS_CYC(FIRST_FS_CYC), .FIRST_HS_CYC(FIRST_HS_CYC)) i_usb_port_seq_checker (.*);

// File: testbench/usb_port_seq_test.sv
// Self-checking testbench for the USB host port sequencer.
`timescale 1ns/10ps
module usb_port_seq_test;
  import usb_port_seq_pkg::*;
  localparam int SPD = 20, TRM = 60, DNE = 10, FFS = 40, FHS = 16;
  logic        pclk, presetn, psel, penable, pwrite, bus_idle, hs_dev, pready, pslverr, dev_chirp_in;
  logic        term_select, drive_se0, chirp_det_en, disc_det_en, sof_pulse, keepalive_pulse, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  xcvr_select, op_mode;
  int          error_cnt = 0, compares = 0, cyc = 0;
  usb_port_seq #(.SPEED_CYC(SPD), .TERM_CYC(TRM), .DONE_CYC(DNE), .FIRST_FS_CYC(FFS), .FIRST_HS_CYC(FHS),
    .SUSP_CYC(30)) i_usb_port_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .dev_chirp_in, .bus_idle, .xcvr_select, .term_select, .op_mode, .drive_se0,
    .chirp_det_en, .disc_det_en, .sof_pulse, .keepalive_pulse, .irq);
  usb_dev_model i_usb_dev_model (.pclk, .hs_dev, .drive_se0, .dev_chirp_in);
  // ****
  // Clock, hang guard and helpers
  // ****
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // A stuck sequence must not run forever.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic chk_rng(input int n, input int lo, input int hi);
    compares++;
    if (n < lo || n > hi) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, n, lo, hi);
    end
  endtask
  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic ctl(input seq_cmd_t c, input logic [1:0] r);
    wr(ADDR_CTRL, {26'h0, r, 1'b0, c});
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic wirq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin @(posedge pclk); n++; end
    chk({31'h0, irq}, 32'h1);
  endtask
  function automatic logic [31:0] pe(logic [1:0] x, logic t, logic [1:0] o, logic s, logic c, logic d);
    return {24'h0, x, t, o, s, c, d};
  endfunction
  function automatic logic [31:0] pv();
    return pe(xcvr_select, term_select, op_mode, drive_se0, chirp_det_en, disc_det_en);
  endfunction
  function automatic logic [31:0] st(phase_t p, logic [1:0] s, logic [1:0] x, logic t, logic [1:0] o);
    return {9'h0, 1'b0, 1'b1, 1'b0, 2'h0, o, 3'h0, t, 2'h0, x, 2'h0, s, 1'b0, p};
  endfunction
  // ****
  // Scenarios
  // ****
  // Run command, then two frame marks of the expected kind and spacing.
  task automatic run(input logic [1:0] r, input logic [1:0] s, input logic [1:0] x, input int f, input logic ka);
    int   n;
    logic k;
    ctl(CMD_RUN, r);
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin @(posedge pclk); n++; end while (sof_pulse !== 1'b1 && keepalive_pulse !== 1'b1 && n < 1000);
      k = keepalive_pulse;
      chk_rng(n, f * 9 / 10, f * 11 / 10 + 1);
      chk({31'h0, k}, {31'h0, ka});
    end
    rd(ADDR_STATUS, st(PH_OPERATIONAL, s, x, TERM_FS, OPM_NORMAL), 1'b0);
    wr(ADDR_EVENT, 32'h7);
  endtask
  task automatic t_regs();
    rd(ADDR_MASK, {29'h0, MASK_RST}, 1'b0);
    rd(ADDR_CTRL, {26'h0, RATE_RST, 4'h0}, 1'b0);
    wr(ADDR_MASK, 32'h7);
    rd(ADDR_MASK, 32'h7, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    $display("register test done");
  endtask
  task automatic t_fs();
    ctl(CMD_BUS_RESET, RATE_HSFS);
    settle();
    chk(pv(), pe(XCVR_HS, TERM_HS, OPM_NORMAL, 1'b1, 1'b1, 1'b0));
    wirq();
    rd(ADDR_STATUS, st(PH_RESET, SPD_FS, XCVR_FS, TERM_FS, OPM_NO_BSNZ) & 32'hffdf_ffff, 1'b0);
    rd(ADDR_EVENT, 32'h1, 1'b0);
    wr(ADDR_EVENT, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0);
    run(RATE_HSFS, SPD_FS, XCVR_FS, FFS, 1'b0);
    $display("full-speed test done");
  endtask
  task automatic t_ls();
    wr(ADDR_MASK, 32'h6);
    ctl(CMD_BUS_RESET, RATE_LS);
    settle();
    chk(pv(), pe(XCVR_HS, TERM_HS, OPM_NORMAL, 1'b1, 1'b0, 1'b0));
    repeat (TRM + DNE + 8) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd(ADDR_STATUS, st(PH_RESET, SPD_LS, XCVR_LS, TERM_FS, OPM_NO_BSNZ) & 32'hffdf_ffff, 1'b0);
    wr(ADDR_MASK, 32'h7);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_EVENT, 32'h1);
    run(RATE_LS, SPD_LS, XCVR_LS, FFS, 1'b1);
    $display("low-speed test done");
  endtask
  task automatic t_hs();
    hs_dev <= 1'b1;
    ctl(CMD_BUS_RESET, RATE_HSFS);
    wirq();
    chk({30'h0, xcvr_select}, {30'h0, XCVR_HS});
    hs_dev <= 1'b0;
    bus_idle <= 1'b0;
    wr(ADDR_EVENT, 32'h1);
    run(RATE_HSFS, SPD_HS, XCVR_HS, FHS, 1'b0);
    ctl(CMD_SLEEP, RATE_HSFS);
    settle();
    chk({29'h0, op_mode, disc_det_en}, {29'h0, OPM_NORMAL, 1'b0});
    @(posedge pclk) bus_idle <= 1'b1;
    wirq();
    chk(pv(), pe(XCVR_FS, TERM_FS, OPM_PWRDN, 1'b0, 1'b0, 1'b1));
    rd(ADDR_EVENT, 32'h4, 1'b0);
    $display("high-speed and sleep test done");
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    bus_idle = 1'b1; hs_dev = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fs();
    t_ls();
    t_hs();
    report_and_stop();
  end
endmodule // usb_port_seq_test
